// File: hdl/iow_consts.svh
// Constants for the port, wake-up and carrier block.
// Assumes a single-cycle data-memory access port from the core.
`ifndef IOW_CONSTS_SVH
`define IOW_CONSTS_SVH
`define IOW_ADDR_BIDIR 7'h05
`define IOW_ADDR_INPUT_PORT_B_PINS 7'h06
`define IOW_ADDR_PORT_C_PINS 7'h07
`define IOW_ADDR_CARRIER_LOW_PERIOD 7'h20
`define IOW_ADDR_CARRIER_HIGH_PERIOD 7'h21
`define IOW_ADDR_PORT_STATUS_CONFIG 7'h24
`define IOW_ADDR_CGCTL 7'h25
`define IOW_PST_PBWAKE 7
`define IOW_PST_PCWAKE 6
`define IOW_PST_PBPULL 5
`define IOW_PST_PC01PULL 4
`define IOW_PST_PC2PULL 3
`define IOW_PST_PC1MODE 2
`define IOW_PST_PC0MODE 0
`define IOW_CG_REMEN 3
`define IOW_CG_LEVEL 2
`define IOW_CG_MH8 1
`define IOW_CG_ML8 0
`define IOW_RST_BIDIR 8'h00
`define IOW_RST_DIR 8'hFF
`define IOW_RST_MOD 8'hFF
`define IOW_RST_PORT_STATUS_CONFIG 8'h20
`define IOW_RST_CGCTL 4'h0
`define IOW_WAKE_VECTOR 10'h3FF
`endif

// File: hdl/iow_pkg.sv
// Types shared by the port block and its carrier counter.
// Assumes iow_consts.svh holds all numeric values.
package iow_pkg;
   typedef logic [8:0] iow_mod_t;
   typedef enum logic [1:0] {
      IOW_AWAKE = 2'b00,
      IOW_ASLEEP = 2'b01,
      IOW_WAKING = 2'b11
   } iow_sleep_t;
endpackage

// File: hdl/iow_carrier_if.sv
// Carrier configuration and output between the port block and the carrier counter.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface iow_carrier_if;
   logic [8:0] lowPeriod;
   logic [8:0] highPeriod;
   logic carrierLevel;
   modport ctrl (output lowPeriod, output highPeriod, input carrierLevel);
   modport gen (input lowPeriod, input highPeriod, output carrierLevel);
endinterface

// File: hdl/iow_carrier.sv
// Carrier generator counting one step per system clock through each half-period.
// Assumes clk runs at twice the nominal core rate.
`timescale 1ns/10ps
module iow_carrier
   import iow_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Configuration and output
   iow_carrier_if.gen cg
);
   iow_mod_t count_r;
   logic level_r;
   iow_mod_t limit;

   ////////////////////////////////////////////////////////////////
   // Zero modulo treated as one to avoid a stuck counter
   assign limit = level_r ? cg.highPeriod : cg.lowPeriod;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_r <= 9'h001;
         level_r <= 1'b0;
      end else if (count_r >= limit) begin
         count_r <= 9'h001;
         level_r <= ~level_r;
      end else begin
         count_r <= count_r + 9'h001;
      end
   end

   assign cg.carrierLevel = level_r;
endmodule

// File: hdl/io_ports_wakeup.sv
// Top of the port, wake-up and carrier block.
// Assumes the core issues one-cycle read/write strobes with a 7-bit data address.
`timescale 1ns/10ps
`include "iow_consts.svh"
module io_ports_wakeup
   import iow_pkg::*;
(
   // Clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic warmRst,
   // Core data-memory access
   input wire logic [6:0] memAddr,
   input wire logic memWr,
   input wire logic memRd,
   input wire logic [7:0] memWdata,
   output logic [7:0] memRdata,
   output logic memHit,
   input wire logic dirLoad,
   input wire logic [6:0] dirAddr,
   input wire logic [7:0] accValue,
   // Sleep control
   input wire logic sleepReq,
   output logic asleep,
   output logic wakeRst,
   output logic [9:0] wakeVector,
   // Bidirectional port pins
   input wire logic [7:0] bidirPortIn,
   output logic [7:0] bidirPortOut,
   output logic [7:0] bidirPortOe_n,
   output logic [7:0] bidirPortPull,
   // Input port B
   input wire logic [7:0] inputPortBIn,
   output logic [7:0] inputPortBPull,
   // Third port pins
   input wire logic thirdPortPin0In,
   output logic thirdPortPin0InEn,
   output logic thirdPortPin0Pull,
   input wire logic thirdPortPin1In,
   output logic thirdPortPin1Out,
   output logic thirdPortPin1Oe_n,
   output logic thirdPortPin1Pull,
   input wire logic thirdPortPin2In,
   output logic thirdPortPin2Pull,
   // Carrier output
   output logic remoteCarrierOut
);
   logic [7:0] bidirData_r;
   logic [7:0] bidirDir_r;
   logic [7:0] lowPeriod_r;
   logic [7:0] highPeriod_r;
   logic [7:0] portStatus_r;
   logic [3:0] carrierCtl_r;
   logic [7:0] bSync1_r;
   logic [7:0] bSync_r;
   logic [7:0] aSync1_r;
   logic [7:0] aSync_r;
   logic [2:0] cSync1_r;
   logic [2:0] cSync_r;
   logic [7:0] bRef_r;
   logic [2:0] cRef_r;
   iow_sleep_t sleep_r;
   iow_sleep_t sleep_nxt;
   logic [7:0] memRdata_r;
   logic [7:0] readMux;
   logic [2:0] portCRead;
   logic [2:0] cWakeMask;
   logic changeSeen;
   logic anyRst;
   logic cgOut;
   logic pc0In;
   logic pc1In;
   iow_carrier_if cgIf ();

   assign anyRst = sys_rst;
   assign pc0In = portStatus_r[`IOW_PST_PC0MODE];
   assign pc1In = portStatus_r[`IOW_PST_PC1MODE];

   ////////////////////////////////////////////////////////////////
   // Pin synchronisers; second stage is the only reader of the first
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bSync1_r <= 8'h00;
         bSync_r <= 8'h00;
      end else begin
         bSync1_r <= inputPortBIn;
         bSync_r <= bSync1_r;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aSync1_r <= 8'h00;
         aSync_r <= 8'h00;
      end else begin
         aSync1_r <= bidirPortIn;
         aSync_r <= aSync1_r;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cSync1_r <= 3'h0;
         cSync_r <= 3'h0;
      end else begin
         cSync1_r <= {thirdPortPin2In, thirdPortPin1In, thirdPortPin0In};
         cSync_r <= cSync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Bidirectional port latch and direction; warm reset also clears the latch and sets every direction bit
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bidirData_r <= `IOW_RST_BIDIR;
         bidirDir_r <= `IOW_RST_DIR;
      end else if (warmRst || wakeRst) begin
         bidirData_r <= `IOW_RST_BIDIR;
         bidirDir_r <= `IOW_RST_DIR;
      end else begin
         if (memWr && memAddr == `IOW_ADDR_BIDIR) begin
            bidirData_r <= memWdata;
         end
         if (dirLoad && dirAddr == `IOW_ADDR_BIDIR) begin
            bidirDir_r <= accValue;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Configuration registers keep their value over a warm reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lowPeriod_r <= `IOW_RST_MOD;
      end else if (memWr && memAddr == `IOW_ADDR_CARRIER_LOW_PERIOD) begin
         lowPeriod_r <= memWdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         highPeriod_r <= `IOW_RST_MOD;
      end else if (memWr && memAddr == `IOW_ADDR_CARRIER_HIGH_PERIOD) begin
         highPeriod_r <= memWdata;
      end
   end

   // Bit 1 is reserved, so it is never stored and always reads zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         portStatus_r <= `IOW_RST_PORT_STATUS_CONFIG;
      end else if (memWr && memAddr == `IOW_ADDR_PORT_STATUS_CONFIG) begin
         portStatus_r <= {memWdata[7:2], 1'b0, memWdata[0]};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         carrierCtl_r <= `IOW_RST_CGCTL;
      end else if (memWr && memAddr == `IOW_ADDR_CGCTL) begin
         carrierCtl_r <= memWdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pin drive and pull-downs
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : gBidir
         assign bidirPortOut[gi] = bidirData_r[gi];
         assign bidirPortOe_n[gi] = bidirDir_r[gi];
         assign bidirPortPull[gi] = bidirDir_r[gi];
         assign inputPortBPull[gi] = portStatus_r[`IOW_PST_PBPULL];
      end
   endgenerate

   assign thirdPortPin0InEn = pc0In;
   assign thirdPortPin0Pull = pc0In && portStatus_r[`IOW_PST_PC01PULL];
   assign thirdPortPin1Pull = pc1In && portStatus_r[`IOW_PST_PC01PULL];
   assign thirdPortPin1Oe_n = pc1In;
   // Indicator follows the carrier while the remote output is enabled
   assign thirdPortPin1Out = cgOut;
   assign thirdPortPin2Pull = portStatus_r[`IOW_PST_PC2PULL];

   ////////////////////////////////////////////////////////////////
   // Carrier generator
   assign cgIf.lowPeriod = {carrierCtl_r[`IOW_CG_ML8], lowPeriod_r};
   assign cgIf.highPeriod = {carrierCtl_r[`IOW_CG_MH8], highPeriod_r};

   iow_carrier uCarrier (
      .clk(clk),
      .sys_rst(anyRst),
      .cg(cgIf.gen)
   );

   // Gated off, the pin rests low; the level bit is stored but steers nothing
   assign cgOut = carrierCtl_r[`IOW_CG_REMEN] && cgIf.carrierLevel;

   // Registered so the pin carries no decode glitches
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         remoteCarrierOut <= 1'b0;
      end else begin
         remoteCarrierOut <= cgOut;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read path
   // Pin 0 in off mode has no input buffer, so it reads high
   always_comb begin
      portCRead[2] = cSync_r[2];
      portCRead[1] = cSync_r[1];
      portCRead[0] = pc0In ? cSync_r[0] : 1'b1;
   end

   always_comb begin
      readMux = 8'h00;
      case (memAddr)
         `IOW_ADDR_BIDIR: readMux = aSync_r;
         `IOW_ADDR_INPUT_PORT_B_PINS: readMux = bSync_r;
         `IOW_ADDR_PORT_C_PINS: readMux = {5'h00, portCRead};
         `IOW_ADDR_CARRIER_LOW_PERIOD: readMux = lowPeriod_r;
         `IOW_ADDR_CARRIER_HIGH_PERIOD: readMux = highPeriod_r;
         `IOW_ADDR_PORT_STATUS_CONFIG: readMux = portStatus_r;
         `IOW_ADDR_CGCTL: readMux = {4'h0, carrierCtl_r};
         default: readMux = 8'h00;
      endcase
   end

   // Read data holds between reads so the core may take it late
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         memRdata_r <= 8'h00;
      end else if (memRd) begin
         memRdata_r <= readMux;
      end
   end
   assign memRdata = memRdata_r;

   always_comb begin
      memHit = 1'b0;
      case (memAddr)
         `IOW_ADDR_BIDIR: memHit = 1'b1;
         `IOW_ADDR_INPUT_PORT_B_PINS: memHit = 1'b1;
         `IOW_ADDR_PORT_C_PINS: memHit = 1'b1;
         `IOW_ADDR_CARRIER_LOW_PERIOD: memHit = 1'b1;
         `IOW_ADDR_CARRIER_HIGH_PERIOD: memHit = 1'b1;
         `IOW_ADDR_PORT_STATUS_CONFIG: memHit = 1'b1;
         `IOW_ADDR_CGCTL: memHit = 1'b1;
         default: memHit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // Wake-up reference: latched on reads, as software must do before sleep
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bRef_r <= 8'h00;
      end else if (memRd && memAddr == `IOW_ADDR_INPUT_PORT_B_PINS) begin
         bRef_r <= bSync_r;
      end
   end

   // A stale reference wakes at once; that is why software reads first
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cRef_r <= 3'h0;
      end else if (memRd && memAddr == `IOW_ADDR_PORT_C_PINS) begin
         cRef_r <= cSync_r;
      end
   end

   assign cWakeMask = {1'b1, pc1In, pc0In} & {3{portStatus_r[`IOW_PST_PCWAKE]}};
   assign changeSeen = ((|(bSync_r ^ bRef_r)) && portStatus_r[`IOW_PST_PBWAKE]) ||
      (|((cSync_r ^ cRef_r) & cWakeMask));

   ////////////////////////////////////////////////////////////////
   // Sleep state machine
   always_comb begin
      sleep_nxt = sleep_r;
      case (sleep_r)
         IOW_AWAKE: begin
            if (sleepReq) begin
               sleep_nxt = IOW_ASLEEP;
            end
         end
         IOW_ASLEEP: begin
            if (changeSeen) begin
               sleep_nxt = IOW_WAKING;
            end
         end
         IOW_WAKING: begin
            sleep_nxt = IOW_AWAKE;
         end
         default: sleep_nxt = IOW_AWAKE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sleep_r <= IOW_AWAKE;
      end else begin
         sleep_r <= sleep_nxt;
      end
   end

   assign asleep = (sleep_r == IOW_ASLEEP);
   assign wakeRst = (sleep_r == IOW_WAKING);
   assign wakeVector = `IOW_WAKE_VECTOR;
endmodule

// File: dv/iow_properties.sv
// Concurrent checks on the port, wake-up and carrier top.
// Assumes a bind to io_ports_wakeup; sees its ports only.
`timescale 1ns/10ps
module iow_properties (
   // Clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic warmRst,
   // Core access
   input wire logic [6:0] memAddr,
   input wire logic memWr,
   input wire logic memRd,
   input wire logic [7:0] memWdata,
   input wire logic [7:0] memRdata,
   input wire logic dirLoad,
   input wire logic [6:0] dirAddr,
   input wire logic [7:0] accValue,
   // Sleep
   input wire logic asleep,
   input wire logic wakeRst,
   input wire logic [9:0] wakeVector,
   // Pins
   input wire logic [7:0] bidirPortOut,
   input wire logic [7:0] bidirPortOe_n,
   input wire logic [7:0] bidirPortPull,
   input wire logic [7:0] inputPortBPull,
   input wire logic thirdPortPin0InEn,
   input wire logic thirdPortPin0Pull,
   input wire logic thirdPortPin1Out,
   input wire logic thirdPortPin1Oe_n,
   input wire logic thirdPortPin1Pull,
   input wire logic thirdPortPin2Pull,
   input wire logic remoteCarrierOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic stWr;
   assign stWr = memWr && memAddr == 7'h24;
   ////////////////////////////////////////
   chk_pull_dir: assert property (bidirPortPull == bidirPortOe_n)
      else $error("pull-down differs from direction");
   chk_dir_load: assert property (dirLoad && dirAddr == 7'h05 && !warmRst && !wakeRst
      |=> bidirPortOe_n == $past(accValue)) else $error("direction not loaded");
   chk_warm_clear: assert property (warmRst || wakeRst |=>
      bidirPortOut == 8'h00 && bidirPortOe_n == 8'hFF) else $error("warm reset missed");
   chk_input_port_b_pins_pull: assert property (stWr |=> inputPortBPull == {8{$past(memWdata[5])}})
      else $error("port B pull-down wrong");
   chk_third_pins: assert property (stWr |=>
      thirdPortPin1Oe_n == $past(memWdata[2])
      && thirdPortPin1Pull == ($past(memWdata[2]) && $past(memWdata[4]))
      && thirdPortPin2Pull == $past(memWdata[3])) else $error("third port pin 1 or 2 wrong");
   chk_pin0_mode: assert property (stWr |=> thirdPortPin0InEn == $past(memWdata[0])
      && thirdPortPin0Pull == ($past(memWdata[0]) && $past(memWdata[4])))
      else $error("third port pin 0 wrong");
   chk_wake_vector: assert property (wakeVector == 10'h3FF)
      else $error("wake vector wrong");
   chk_wake_pulse: assert property (wakeRst |-> $past(asleep) ##1 !wakeRst)
      else $error("wake pulse without sleep");
   chk_port_c_pins_upper: assert property (memRd && memAddr == 7'h07 |=> memRdata[7:3] == 5'h00)
      else $error("third port upper bits set");
   chk_carrier_gate: assert property (memWr && memAddr == 7'h25 && !memWdata[3]
      |-> ##2 !remoteCarrierOut) else $error("carrier not gated off");
   chk_led_follow: assert property (remoteCarrierOut == $past(thirdPortPin1Out))
      else $error("indicator does not follow carrier");
endmodule
bind io_ports_wakeup iow_properties chkInst (.*);

// File: dv/iow_pin_model.sv
// Outside world at the bidirectional port and third-port pin 1.
// Assumes the bench gives the external drive; floating lines toggle.
`timescale 1ns/10ps
module iow_pin_model (
   // Design side
   input wire logic clk,
   input wire logic [7:0] bidirPortOut,
   input wire logic [7:0] bidirPortOe_n,
   input wire logic [7:0] bidirPortPull,
   input wire logic thirdPortPin1Out,
   input wire logic thirdPortPin1Oe_n,
   input wire logic thirdPortPin1Pull,
   // External drivers
   input wire logic [7:0] extA,
   input wire logic [7:0] extAEn,
   input wire logic extPin1,
   input wire logic extPin1En,
   // Resolved levels
   output logic [7:0] bidirPortIn,
   output logic thirdPortPin1In
);
   // Undriven, unpulled lines change every cycle so no value is guessed
   logic [8:0] flt_r = 9'h0AA;
   always @(posedge clk) flt_r <= ~flt_r;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         bidirPortIn[i] = !bidirPortOe_n[i] ? bidirPortOut[i] : extAEn[i] ? extA[i] :
            bidirPortPull[i] ? 1'b0 : flt_r[i];
      end
      thirdPortPin1In = !thirdPortPin1Oe_n ? thirdPortPin1Out : extPin1En ? extPin1 :
         thirdPortPin1Pull ? 1'b0 : flt_r[8];
   end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the port, wake-up and carrier block.
// Assumes the checker is bound in and the pin model closes the pins.
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic warmRst = 1'b0, memWr = 1'b0, memRd = 1'b0, dirLoad = 1'b0, sleepReq = 1'b0;
   logic [6:0] memAddr = 7'h00, dirAddr = 7'h00;
   logic [7:0] memWdata = 8'h00, accValue = 8'h00, inputPortBIn = 8'h00;
   logic [7:0] extA = 8'h00, extAEn = 8'h00, memRdata, bidirPortIn, bidirPortOut;
   logic [7:0] bidirPortOe_n, bidirPortPull, inputPortBPull, expQ[$], v, a, d;
   logic thirdPortPin0In = 1'b0, thirdPortPin2In = 1'b0, extPin1 = 1'b0, extPin1En = 1'b0;
   logic memHit, asleep, wakeRst, thirdPortPin0InEn, thirdPortPin0Pull, thirdPortPin1In;
   logic thirdPortPin1Out, thirdPortPin1Oe_n, thirdPortPin1Pull, thirdPortPin2Pull;
   logic remoteCarrierOut, rdPend = 1'b0;
   logic [9:0] wakeVector;
   int num_errors = 0, n_checks = 0, cyc = 0, seed = 97576, n;
   io_ports_wakeup DUT (.*);
   iow_pin_model pins (.*);
   always #4 clk = ~clk;
   ////////////////////////////////////////
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Strobes stay up until the next call, so back-to-back never double-assigns
   task automatic acc(input logic w, input logic r, input logic [6:0] ad, input logic [7:0] dt);
      memWr = w;
      memRd = r;
      memAddr = ad;
      memWdata = dt;
      @(negedge clk);
   endtask
   task automatic rd(input logic [6:0] ad, input logic [7:0] e);
      expQ.push_back(e);
      acc(1'b0, 1'b1, ad, 8'h00);
   endtask
   task automatic idle(input int k);
      repeat (k) acc(1'b0, 1'b0, 7'h00, 8'h00);
   endtask
   task automatic width(input logic lvl, input int exp);
      n = 0;
      while (remoteCarrierOut === lvl && n < 600) begin
         @(negedge clk);
         n++;
      end
      while (remoteCarrierOut !== lvl && n < 1200) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (remoteCarrierOut === lvl && n < 600) begin
         @(negedge clk);
         n++;
      end
      chk(n[9:0], exp[9:0]);
      chk(thirdPortPin1Out, !lvl);
   endtask
   task automatic wake_wait(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (20) begin
         @(negedge clk);
         if (wakeRst === 1'b1) seen = 1'b1;
      end
      chk(seen, exp);
   endtask
   ////////////////////////////////////////
   always @(posedge clk) rdPend <= memRd;
   always @(negedge clk) if (rdPend === 1'b1) chk(memRdata, expQ.pop_front());
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      idle(1);
      chk(bidirPortOe_n, 8'hFF);
      chk(bidirPortOut, 8'h00);
      rd(7'h05, 8'h00);
      rd(7'h20, 8'hFF);
      rd(7'h21, 8'hFF);
      rd(7'h24, 8'h20);
      rd(7'h25, 8'h00);
      rd(7'h07, 8'h01);
      rd(7'h30, 8'h00);
      acc(1'b1, 1'b0, 7'h30, 8'h5A);
      chk(memHit, 1'b0);
      repeat (3) begin
         a = 8'($random(seed));
         d = 8'($random(seed));
         extA = 8'($random(seed));
         extAEn = a & 8'($random(seed));
         dirLoad = 1'b1;
         dirAddr = 7'h05;
         accValue = a;
         acc(1'b1, 1'b0, 7'h05, d);
         chk(memHit, 1'b1);
         dirAddr = 7'h06;
         accValue = ~a;
         idle(1);
         dirLoad = 1'b0;
         idle(3);
         chk(bidirPortOe_n, a);
         chk(bidirPortOut, d);
         rd(7'h05, (d & ~a) | (extA & extAEn));
         idle(1);
      end
      warmRst = 1'b1;
      idle(1);
      warmRst = 1'b0;
      idle(1);
      chk(bidirPortOe_n, 8'hFF);
      chk(bidirPortOut, 8'h00);
      repeat (4) begin
         v = 8'($random(seed));
         inputPortBIn = 8'($random(seed));
         {thirdPortPin0In, extPin1, thirdPortPin2In} = 3'($random(seed));
         extPin1En = v[2];
         acc(1'b1, 1'b0, 7'h24, v);
         idle(3);
         chk(inputPortBPull, {8{v[5]}});
         rd(7'h24, v & 8'hFD);
         rd(7'h06, inputPortBIn);
         rd(7'h07, {5'h00, thirdPortPin2In, v[2] & extPin1, !v[0] | thirdPortPin0In});
         idle(1);
      end
      acc(1'b1, 1'b0, 7'h24, 8'h00);
      acc(1'b1, 1'b0, 7'h20, 8'h03);
      acc(1'b1, 1'b0, 7'h21, 8'h05);
      acc(1'b1, 1'b0, 7'h25, 8'h08);
      idle(1);
      width(1'b1, 5);
      width(1'b0, 3);
      acc(1'b1, 1'b0, 7'h25, 8'h09);
      rd(7'h25, 8'h09);
      idle(1);
      width(1'b0, 259);
      acc(1'b1, 1'b0, 7'h25, 8'h01);
      idle(4);
      chk(remoteCarrierOut, 1'b0);
      {inputPortBIn, thirdPortPin0In, thirdPortPin2In} = 10'h000;
      dirLoad = 1'b1;
      dirAddr = 7'h05;
      accValue = 8'h00;
      acc(1'b1, 1'b0, 7'h24, 8'h41);
      dirLoad = 1'b0;
      idle(3);
      rd(7'h07, 8'h00);
      rd(7'h06, 8'h00);
      sleepReq = 1'b1;
      idle(1);
      sleepReq = 1'b0;
      idle(1);
      chk(asleep, 1'b1);
      inputPortBIn = 8'h10;
      wake_wait(1'b0);
      thirdPortPin2In = 1'b1;
      wake_wait(1'b1);
      chk(asleep, 1'b0);
      chk(bidirPortOe_n, 8'hFF);
      acc(1'b1, 1'b0, 7'h24, 8'hA0);
      idle(2);
      rd(7'h06, 8'h10);
      sleepReq = 1'b1;
      idle(1);
      sleepReq = 1'b0;
      inputPortBIn = 8'h11;
      wake_wait(1'b1);
      idle(2);
      end_of_test();
   end
endmodule
